//--- common/srcs_defines.vh
`ifndef SRCS_DEFINES_VH
`define SRCS_DEFINES_VH
// register offsets (byte addresses)
`define SRCS_ADDR_CAUSE 8'h00
`define SRCS_ADDR_CONFIG 8'h04
`define SRCS_ADDR_STATUS 8'h08
// reset cause register bit positions
`define SRCS_BIT_POWER 7
`define SRCS_BIT_PIN 6
`define SRCS_BIT_WDOG 5
`define SRCS_BIT_BADOP 4
`define SRCS_BIT_BADADR 3
`define SRCS_BIT_BROWN 1
`define SRCS_CAUSE_POR 8'h80
// config register bit positions
`define SRCS_CFG_SHORTREC 0
`define SRCS_CFG_WDOGDIS 1
`define SRCS_CFG_BOPWRDIS 2
`define SRCS_CFG_BORSTDIS 3
`define SRCS_CFG_STOPEN 4
`define SRCS_CFG_RESET 8'h00
// reference clock counts
`define SRCS_LONG_TICKS 4096
`define SRCS_SHORT_TICKS 32
`define SRCS_DRIVE_TICKS 32
`define SRCS_HOLD_TICKS 32
`define SRCS_POR_HOLD_TICKS 64
`define SRCS_PIN_TICKS 67
`define SRCS_PIN_POR_TICKS 4163
// reset vectors
`define SRCS_VEC_USER 16'hfffe
`define SRCS_VEC_MON 16'hfefe
`endif

//--- rtl/srcs_sequencer.v
// Operation
// - power-up/brownout: clocks off, pin low 4096
// - stop exit: count reference clock before clocks
// - short recovery bit selects 32-cycle delay
// - every source asserts internal reset, selects vector
// - internal reset clears counter, pin does not
// - each source sets its own cause flag
// - pin flag needs 67 or 4163 low cycles
// - internal sources drive pin 32, hold 32
// - after power-up pin period, wait 64 more
// - power-up sets power flag, clears others
// - watchdog overflow resets unless watchdog disabled
// - illegal instruction sets flag and resets
// - stop without stop enable is illegal opcode
// - only unmapped opcode fetches cause address reset
// - brownout resets, pin low until 4096 after
// - 12-bit counter on reference falling edge, clocks watchdog
// - stop instruction clears the system counter
// - counter runs freely after reset states
// - power-up enables clock generator output
// - wait stops cpu clocks, peripherals keep running
// - external low pin halts all processing
// - cause register bit layout, bits 2,0 zero
`timescale 1ns/1ps
`include "srcs_defines.vh"
module srcs_sequencer #(
   parameter LONG_TICKS = `SRCS_LONG_TICKS,
   parameter PIN_POR_TICKS = `SRCS_PIN_POR_TICKS
) (
   input wire sys_clk_i, // system clock
   input wire rst_i, // async reset, high
   input wire ce_i, // clock enable, freezes state when low
   input wire osc_reference_clock_i, // oscillator reference clock, async
   input wire power_up_pulse_i, // power-on detector pulse, async
   input wire brownout_i, // brownout detector output, async
   input wire wdog_overflow_i, // watchdog overflow, async
   input wire rst_pin_i, // reset pin level
   input wire bad_instr_i, // cpu illegal instruction decode
   input wire stop_exec_i, // cpu executes stop
   input wire wait_exec_i, // cpu executes wait
   input wire opcode_fetch_i, // cpu cycle is an opcode fetch
   input wire addr_unmapped_i, // current address is unmapped
   input wire wake_i, // interrupt or break wake request
   input wire monitor_mode_i, // monitor mode selects alternate vector
   input wire [7:0] addr_i, // register address
   input wire [7:0] wr_data_i, // register write data
   input wire wr_i, // write strobe
   input wire rd_i, // read strobe
   output reg [7:0] rd_data_o, // read data, cycle after strobe
   output reg rst_pin_o, // reset pin drive level (always low)
   output reg rst_pin_oe_o, // reset pin output enable
   output reg internal_reset_o, // internal reset to all modules
   output reg cpu_clk_en_o, // cpu clock enable
   output reg per_clk_en_o, // peripheral clock enable
   output reg clock_gen_output_en_o, // clock generator output enable
   output reg wdog_clk_o, // watchdog clock pulse on counter overflow
   output reg [15:0] reset_vector_o // reset vector address for cpu
);
   localparam [7:0] S_POR = 8'h01; // pin low, long count
   localparam [7:0] S_DRIVE = 8'h02; // pin low, internal source
   localparam [7:0] S_HOLD = 8'h04; // pin released, reset held
   localparam [7:0] S_EXT = 8'h08; // pin held low from outside
   localparam [7:0] S_RUN = 8'h10;
   localparam [7:0] S_WAIT = 8'h20;
   localparam [7:0] S_STOP = 8'h40;
   localparam [7:0] S_REC = 8'h80; // stop recovery count
   localparam [12:0] SHORT_LAST = `SRCS_SHORT_TICKS - 1; // last tick of short recovery
   localparam [12:0] LONG_LAST = LONG_TICKS - 1; // last tick of long count
   localparam [12:0] PIN_LAST = `SRCS_PIN_TICKS - 1; // pin flag threshold, normal
   localparam [12:0] PIN_POR_LAST = PIN_POR_TICKS - 1; // pin flag threshold, power-up

   reg [7:0] state_q, state_d;
   reg [12:0] seq_q, seq_d;
   reg [11:0] cnt_q, cnt_d;
   reg [12:0] pin_cnt_q, pin_cnt_d;
   reg [7:0] cause_q, cause_d;
   reg [7:0] cfg_q;
   reg hold_long_q, hold_long_d;
   reg por_act_q, por_act_d;
   reg pin_hi_q, pin_hi_d;
   reg ref_s1_q, ref_s2_q, ref_s3_q;
   reg pin_s1_q, pin_s2_q;
   reg pu_s1_q, pu_s2_q;
   reg bo_s1_q, bo_s2_q;
   reg wd_s1_q, wd_s2_q;
   reg [12:0] rec_last;
   reg [12:0] pin_thr;
   wire tick;
   wire brown_evt;
   wire wdog_evt;
   wire badop_evt;
   wire badadr_evt;
   wire pin_ext;
   wire live;

   // two-flop synchronisers for every pin-side input
   always @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
         ref_s3_q <= 1'b0;
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
         pu_s1_q <= 1'b0;
         pu_s2_q <= 1'b0;
         bo_s1_q <= 1'b0;
         bo_s2_q <= 1'b0;
         wd_s1_q <= 1'b0;
         wd_s2_q <= 1'b0;
      end
      else if (ce_i)
      begin
         ref_s1_q <= osc_reference_clock_i;
         ref_s2_q <= ref_s1_q;
         ref_s3_q <= ref_s2_q;
         pin_s1_q <= rst_pin_i;
         pin_s2_q <= pin_s1_q;
         pu_s1_q <= power_up_pulse_i;
         pu_s2_q <= pu_s1_q;
         bo_s1_q <= brownout_i;
         bo_s2_q <= bo_s1_q;
         wd_s1_q <= wdog_overflow_i;
         wd_s2_q <= wd_s1_q;
      end
   end

   // falling edge of the reference clock; it must run well below sys_clk/2
   assign tick = ref_s3_q & ~ref_s2_q;
   // watchdog, opcode and address sources are only acted on once the chip is out of reset; the pin also once it has risen in S_HOLD
   assign live = (state_q == S_RUN) | (state_q == S_WAIT) | (state_q == S_STOP);
   assign brown_evt = bo_s2_q & ~cfg_q[`SRCS_CFG_BOPWRDIS] & ~cfg_q[`SRCS_CFG_BORSTDIS];
   assign wdog_evt = wd_s2_q & ~cfg_q[`SRCS_CFG_WDOGDIS];
   // stop is illegal unless enabled
   assign badop_evt = (state_q == S_RUN) &
      (bad_instr_i | (stop_exec_i & ~cfg_q[`SRCS_CFG_STOPEN]));
   // data accesses to unmapped space are harmless
   assign badadr_evt = (state_q == S_RUN) & opcode_fetch_i & addr_unmapped_i;
   // low pin that we are not driving ourselves
   assign pin_ext = ~pin_s2_q & ~rst_pin_oe_o;

   // recovery length and pin flag threshold
   always @*
   begin
      if (cfg_q[`SRCS_CFG_SHORTREC])
         rec_last = SHORT_LAST;
      else
         rec_last = LONG_LAST;
      if (por_act_q)
         pin_thr = PIN_POR_LAST;
      else
         pin_thr = PIN_LAST;
   end

   // sequencing state machine, system counter and cause flags
   always @*
   begin
      state_d = state_q;
      seq_d = seq_q;
      hold_long_d = hold_long_q;
      por_act_d = por_act_q;
      pin_hi_d = ((state_q == S_HOLD) & (pin_hi_q | pin_s2_q)) | (state_q == S_EXT); // sync lag is not a pull
      cnt_d = tick ? cnt_q + 12'h001 : cnt_q;
      // read clears flags; a set in the same cycle wins below
      if (rd_i && addr_i == `SRCS_ADDR_CAUSE)
         cause_d = 8'h00;
      else
         cause_d = cause_q;
      // pin low time in reference cycles, saturating
      if (pin_s2_q)
         pin_cnt_d = 13'h0000;
      else if (tick && pin_cnt_q != 13'h1fff)
         pin_cnt_d = pin_cnt_q + 13'h0001;
      else
         pin_cnt_d = pin_cnt_q;
      if (tick && ~pin_s2_q && pin_cnt_q == pin_thr)
         cause_d[`SRCS_BIT_PIN] = 1'b1;
      if (pu_s2_q)
      begin
         state_d = S_POR;
         seq_d = 13'h0000;
         cnt_d = 12'h000;
         por_act_d = 1'b1;
         cause_d = `SRCS_CAUSE_POR;
      end
      else if (brown_evt && state_q != S_POR)
      begin
         state_d = S_POR;
         seq_d = 13'h0000;
         cnt_d = 12'h000;
         por_act_d = 1'b1;
         cause_d[`SRCS_BIT_BROWN] = 1'b1;
      end
      else if (live && (wdog_evt || badop_evt || badadr_evt))
      begin
         state_d = S_DRIVE;
         seq_d = 13'h0000;
         cnt_d = 12'h000;
         if (wdog_evt)
            cause_d[`SRCS_BIT_WDOG] = 1'b1;
         if (badop_evt)
            cause_d[`SRCS_BIT_BADOP] = 1'b1;
         if (badadr_evt)
            cause_d[`SRCS_BIT_BADADR] = 1'b1;
      end
      else if (live && pin_ext)
      begin
         state_d = S_EXT; // counter left alone
      end
      else
      begin
         case (state_q)
            S_POR:
            begin
               // brownout still present keeps the long count at zero
               if (brown_evt)
                  seq_d = 13'h0000;
               else if (tick)
               begin
                  if (seq_q == LONG_LAST)
                  begin
                     state_d = S_HOLD;
                     seq_d = 13'h0000;
                     hold_long_d = 1'b1;
                  end
                  else
                     seq_d = seq_q + 13'h0001;
               end
            end
            S_DRIVE:
            begin
               if (tick)
               begin
                  if (seq_q == `SRCS_DRIVE_TICKS - 1)
                  begin
                     state_d = S_HOLD;
                     seq_d = 13'h0000;
                     hold_long_d = 1'b0;
                  end
                  else
                     seq_d = seq_q + 13'h0001;
               end
            end
            S_EXT:
            begin
               // processing stays halted while the pin is low
               if (pin_s2_q)
               begin
                  state_d = S_HOLD;
                  seq_d = 13'h0000;
                  hold_long_d = 1'b0;
               end
            end
            S_HOLD:
            begin
               if (~pin_s2_q && pin_hi_q)
                  state_d = S_EXT;
               else if (tick)
               begin
                  if ((hold_long_q && seq_q == `SRCS_POR_HOLD_TICKS - 1) ||
                      (!hold_long_q && seq_q == `SRCS_HOLD_TICKS - 1))
                  begin
                     state_d = S_RUN;
                     por_act_d = 1'b0;
                  end
                  else
                     seq_d = seq_q + 13'h0001;
               end
            end
            S_RUN:
            begin
               if (stop_exec_i)
               begin
                  state_d = S_STOP;
                  cnt_d = 12'h000;
               end
               else if (wait_exec_i)
                  state_d = S_WAIT;
            end
            S_WAIT:
            begin
               if (wake_i)
                  state_d = S_RUN;
            end
            S_STOP:
            begin
               if (wake_i)
               begin
                  state_d = S_REC;
                  seq_d = 13'h0000;
               end
            end
            S_REC:
            begin
               // counts from a cleared counter
               if (tick)
               begin
                  if (seq_q == rec_last)
                     state_d = S_RUN;
                  else
                     seq_d = seq_q + 13'h0001;
               end
            end
            default:
               state_d = S_POR;
         endcase
      end
   end

   // sequencer registers; reset behaves as a power-up
   always @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= S_POR;
         seq_q <= 13'h0000;
         cnt_q <= 12'h000;
         pin_cnt_q <= 13'h0000;
         cause_q <= `SRCS_CAUSE_POR;
         hold_long_q <= 1'b1;
         por_act_q <= 1'b1;
         pin_hi_q <= 1'b0;
      end
      else if (ce_i)
      begin
         state_q <= state_d;
         seq_q <= seq_d;
         cnt_q <= cnt_d;
         pin_cnt_q <= pin_cnt_d;
         cause_q <= cause_d;
         hold_long_q <= hold_long_d;
         por_act_q <= por_act_d;
         pin_hi_q <= pin_hi_d;
      end
   end

   // outputs registered from next state so they align with state_q
   always @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rst_pin_o <= 1'b0;
         rst_pin_oe_o <= 1'b1;
         internal_reset_o <= 1'b1;
         cpu_clk_en_o <= 1'b0;
         per_clk_en_o <= 1'b0;
         clock_gen_output_en_o <= 1'b1;
         wdog_clk_o <= 1'b0;
         reset_vector_o <= `SRCS_VEC_USER;
      end
      else if (ce_i)
      begin
         rst_pin_o <= 1'b0;
         rst_pin_oe_o <= (state_d == S_POR) | (state_d == S_DRIVE);
         internal_reset_o <= (state_d == S_POR) | (state_d == S_DRIVE) |
            (state_d == S_HOLD) | (state_d == S_EXT);
         cpu_clk_en_o <= (state_d == S_RUN);
         per_clk_en_o <= (state_d == S_RUN) | (state_d == S_WAIT);
         clock_gen_output_en_o <= 1'b1;
         wdog_clk_o <= tick & (cnt_q == 12'hfff);
         reset_vector_o <= monitor_mode_i ? `SRCS_VEC_MON : `SRCS_VEC_USER;
      end
   end

   // register port: config write, reads answered one cycle later
   always @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cfg_q <= `SRCS_CFG_RESET;
         rd_data_o <= 8'h00;
      end
      else if (ce_i)
      begin
         if (wr_i && addr_i == `SRCS_ADDR_CONFIG)
            cfg_q <= {3'h0, wr_data_i[4:0]};
         rd_data_o <= 8'h00;
         if (rd_i)
         begin
            if (addr_i == `SRCS_ADDR_CAUSE)
               rd_data_o <= {cause_q[7:3], 1'b0, cause_q[1], 1'b0};
            else if (addr_i == `SRCS_ADDR_CONFIG)
               rd_data_o <= cfg_q;
            else if (addr_i == `SRCS_ADDR_STATUS)
               rd_data_o <= state_q;
            else
               rd_data_o <= 8'h00;
         end
      end
   end
endmodule

//--- test/srcs_pin_party.sv
`timescale 1ns/1ps
module srcs_pin_party (
   input wire dev_oe_i, // device enable
   input wire dev_lvl_i, // device drive level
   input wire ext_low_i, // outside chip pulls low
   output wire pin_lvl_o // wire level
);
   // open-drain line with pull-up; any party pulling low wins
   assign pin_lvl_o = !((dev_oe_i && !dev_lvl_i) || ext_low_i);
endmodule

//--- test/srcs_sequencer_sva.sv
`timescale 1ns/1ps
module srcs_sequencer_sva (
   input wire sys_clk_i, // clock
   input wire rst_i, // reset
   input wire rst_pin_i, // pin level
   input wire bad_instr_i, // bad decode
   input wire opcode_fetch_i, // fetch cycle
   input wire addr_unmapped_i, // unmapped
   input wire monitor_mode_i, // vector select
   input wire rd_i, // read strobe
   input wire [7:0] addr_i, // address
   input wire [7:0] rd_data_o, // read data
   input wire rst_pin_o, // pin drive level
   input wire rst_pin_oe_o, // pin enable
   input wire internal_reset_o, // reset out
   input wire cpu_clk_en_o, // cpu clock
   input wire per_clk_en_o, // peripheral clock
   input wire clock_gen_output_en_o, // clock gen
   input wire [15:0] reset_vector_o // vector
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // pin drive always sits inside an internal reset span
   a_drive_in_reset: assert property (rst_pin_oe_o |-> internal_reset_o)
      else $error("pin driven outside reset");
   a_clk_gated: assert property (internal_reset_o |-> !cpu_clk_en_o && !per_clk_en_o)
      else $error("clocks run in reset");
   a_wait_per: assert property (cpu_clk_en_o |-> per_clk_en_o)
      else $error("cpu clock without peripheral clock");
   a_pin_low: assert property (!rst_pin_o)
      else $error("pin drive level high");
   a_cgen_on: assert property (clock_gen_output_en_o)
      else $error("clock generator off");
   // $past guard keeps the first edge after reset quiet
   a_vector_sel: assert property (!$past(rst_i) |->
      reset_vector_o == ($past(monitor_mode_i) ? 16'hfefe : 16'hfffe))
      else $error("wrong vector");
   a_cause_zeros: assert property ($past(rd_i) && $past(addr_i) == 8'h00 |->
      rd_data_o[2] == 1'b0 && rd_data_o[0] == 1'b0)
      else $error("cause spare bit set");
   a_rd_idle: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
      else $error("read data outside read cycle");
   a_bad_op_rst: assert property (bad_instr_i && cpu_clk_en_o |-> ##[1:3] rst_pin_oe_o)
      else $error("no reset on bad op");
   a_bad_fetch: assert property (cpu_clk_en_o && opcode_fetch_i && addr_unmapped_i
      |-> ##[1:3] rst_pin_oe_o)
      else $error("no reset on bad fetch");
   // sync flops add a few cycles before the halt shows
   a_ext_halt: assert property (!rst_pin_i [*6] |-> !cpu_clk_en_o)
      else $error("cpu runs with pin low");
endmodule
bind srcs_sequencer srcs_sequencer_sva u_sva (.*);

//--- test/srcs_sequencer_tb_top.sv
`timescale 1ns/1ps
module srcs_sequencer_tb_top;
   logic clk = 0, rst = 1, ref_clk = 0, pup = 0, brown = 0, wdog = 0, mon = 0, ext_low = 0;
   logic wr = 0, rd = 0, pin_lvl, oe, pin_o, internal_reset, cpu_en, per_en, cgen, wclk;
   logic [5:0] ev = 6'h00; // bad, stop, wait, fetch, unmapped, wake
   logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
   logic [15:0] vec;
   int miscompares = 0, tests_run = 0, ticks = 0, t, i, t1;
   always #2 clk = ~clk;
   // reference ticks: 8 system clocks, phase never on a rising clk edge
   always #16 ref_clk = ~ref_clk;
   always @(negedge ref_clk) ticks++;
   srcs_pin_party u_pin (.dev_oe_i(oe), .dev_lvl_i(pin_o), .ext_low_i(ext_low), .pin_lvl_o(pin_lvl));
   srcs_sequencer #(.LONG_TICKS(64), .PIN_POR_TICKS(131)) dut (.sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1),
      .osc_reference_clock_i(ref_clk), .power_up_pulse_i(pup), .brownout_i(brown), .wdog_overflow_i(wdog),
      .rst_pin_i(pin_lvl), .bad_instr_i(ev[0]), .stop_exec_i(ev[1]), .wait_exec_i(ev[2]),
      .opcode_fetch_i(ev[3]), .addr_unmapped_i(ev[4]), .wake_i(ev[5]), .monitor_mode_i(mon),
      .addr_i(addr), .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .rst_pin_o(pin_o),
      .rst_pin_oe_o(oe), .internal_reset_o(internal_reset), .cpu_clk_en_o(cpu_en), .per_clk_en_o(per_en),
      .clock_gen_output_en_o(cgen), .wdog_clk_o(wclk), .reset_vector_o(vec));
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, exp, got);
      end
   endtask
   // tick counts may slip by the sync latency, so allow a small margin
   task near(input string n, input int got, input int exp);
      chk(n, {15'h0000, got >= exp - 2 && got <= exp + 2}, 16'h0001);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task rdchk(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1;
      chk(n, {8'h00, rdat}, {8'h00, e});
   endtask
   task hit(input logic [5:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 6'h00;
      #1;
   endtask
   // sel 0: pin drive ends, 1: internal reset ends, 2: cpu clock runs, 3: watchdog clock pulse
   task waitx(input int sel, output int n);
      int t0;
      int k;
      t0 = ticks;
      for (k = 0; k < 40000; k++)
      begin
         cyc(1);
         if (sel == 0 && oe !== 1'b1 || sel == 1 && internal_reset !== 1'b1 || sel == 2 && cpu_en === 1'b1 ||
             sel == 3 && wclk === 1'b1)
            break;
      end
      n = ticks - t0;
      if (k == 40000)
      begin
         miscompares++;
         complete_run;
      end
   endtask
   task cause_after(input logic [7:0] e);
      cyc(8);
      waitx(2, t);
      rdchk(8'h00, e, "cause");
   endtask
   initial
   begin
      cyc(10);
      rst <= 0;
      waitx(0, t);
      near("power pin low", t, 64);
      waitx(1, t);
      near("power hold", t, 64);
      rdchk(8'h00, 8'h80, "power cause");
      rdchk(8'h04, 8'h00, "config");
      rdchk(8'h0c, 8'h00, "unmapped");
      chk("vector", vec, 16'hfffe);
      chk("clock gen", {15'h0000, cgen}, 16'h0001);
      hit(6'h01);
      waitx(0, t);
      near("drive span", t, 32);
      waitx(1, t);
      near("hold span", t, 32);
      rdchk(8'h00, 8'h10, "bad op");
      rdchk(8'h00, 8'h00, "read clear");
      hit(6'h02); // stop while stop is disabled
      cause_after(8'h10);
      hit(6'h10); // data access to unmapped place
      cyc(20);
      chk("data access", {15'h0000, internal_reset}, 16'h0000);
      hit(6'h18);
      cause_after(8'h08);
      wr_reg(8'h04, 8'h02);
      wdog <= 1;
      cyc(4);
      wdog <= 0;
      cyc(20);
      chk("watchdog off", {15'h0000, internal_reset}, 16'h0000);
      wr_reg(8'h04, 8'h00);
      wdog <= 1;
      cyc(4);
      wdog <= 0;
      cause_after(8'h20);
      brown <= 1;
      cyc(40);
      brown <= 0;
      cause_after(8'h02);
      ext_low <= 1; // outside chip holds pin past the flag limit
      cyc(640);
      chk("halt", {15'h0000, cpu_en}, 16'h0000);
      ext_low <= 0;
      cause_after(8'h40);
      ext_low <= 1;
      cyc(160);
      ext_low <= 0;
      cause_after(8'h00);
      for (i = 0; i < 2; i++)
      begin
         wr_reg(8'h04, i ? 8'h11 : 8'h10);
         hit(6'h02);
         cyc(4);
         chk("stop clocks", {15'h0000, cpu_en}, 16'h0000);
         ev <= 6'h20;
         waitx(2, t);
         ev <= 6'h00;
         near("recovery", t, i ? 32 : 64);
      end
      hit(6'h04);
      cyc(4);
      chk("wait clocks", {14'h0000, cpu_en, per_en}, 16'h0001);
      ev <= 6'h20;
      waitx(2, t);
      ev <= 6'h00;
      mon <= 1;
      cyc(3);
      chk("monitor vector", vec, 16'hfefe);
      mon <= 0;
      cyc(3);
      // internal reset clears the counter, an outside pull in between must not
      hit(6'h01);
      t1 = ticks;
      waitx(1, t);
      ext_low <= 1;
      cyc(160);
      ext_low <= 0;
      waitx(3, t);
      near("watchdog clock", ticks - t1, 4096);
      // power-up pulse replaces the unread bad op flag
      pup <= 1;
      cyc(4);
      pup <= 0;
      cause_after(8'h80);
      complete_run;
   end
endmodule
